// *** common/ccd_pkg.sv ***
/*
  Package for the codec auxiliary clock divider block: register offsets, field
  positions, reset values, target frequencies and the divider code search.
  Assumes registers are 16 bits wide and addressed by an 8-bit index.
*/
package ccd_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CLOCK_CONFIG_TWO = 8'h08;
  localparam logic [7:0] ADDR_MISC_CONTROL_ONE = 8'h17;
  localparam logic [7:0] ADDR_POWER_MANAGEMENT_ONE = 8'h19;
  localparam logic [7:0] ADDR_CLOCK_CONFIG_THREE = 8'h1e;
  localparam logic [7:0] ADDR_CLOCK_CONFIG_FOUR = 8'h38;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int SPK_DIV_LSB = 6;
  localparam int HOUSE_DIV_LSB = 1;
  localparam int SERVO_DIV_LSB = 5;
  localparam int GP_EN_BIT = 9;
  localparam int TO_EN_BIT = 0;
  localparam int TO_DIV_LSB = 7;
  localparam int GP_DIV_LSB = 10;
  localparam int DB_DIV_LSB = 13;
  localparam int CLK3_RW_LSB = 7;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] SPK_DIV_RST = 3'h7;
  localparam logic [5:0] HOUSE_DIV_RST = 6'h2f;
  localparam logic [3:0] SERVO_DIV_RST = 4'h8;
  localparam logic [15:0] REG_RW_RST = 16'h0000;
  localparam logic [8:0] CLK3_RW_RST = 9'h000;

  // ------------------------------------------------------------------
  // Target frequencies in kHz, code counts and debounce skip exponent
  // ------------------------------------------------------------------
  localparam logic [15:0] TGT_CLASSD_KHZ = 16'h0300;
  localparam logic [15:0] TGT_HOUSE_KHZ = 16'h0100;
  localparam logic [15:0] TGT_SERVO_KHZ = 16'h05dc;
  localparam logic [6:0] NCODES_EIGHT = 7'h08;
  localparam logic [6:0] NCODES_LINEAR = 7'h40;
  localparam logic [6:0] NCODES_SERVO = 7'h09;
  localparam int DB_SKIP_LOG2 = 2;

  // ------------------------------------------------------------------
  // Divider families
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_EIGHT = 2'h0,
    KIND_LINEAR = 2'h1,
    KIND_SERVO = 2'h3
  } ccd_kind_e;

  // Ratio in half units for a code; zero marks a reserved code
  function automatic logic [7:0] half_ratio(input ccd_kind_e k, input logic [5:0] c);
    logic [7:0] h;
    h = 8'h00;
    if (k == KIND_EIGHT)
    begin
      case (c[2:0])
        3'h0: h = 8'h02;
        3'h1: h = 8'h04;
        3'h2: h = 8'h06;
        3'h3: h = 8'h08;
        3'h4: h = 8'h0c;
        3'h5: h = 8'h10;
        3'h6: h = 8'h18;
        default: h = 8'h20;
      endcase
    end
    else if (k == KIND_LINEAR)
    begin
      h = 8'({1'b0, c, 1'b0}) + 8'h02;
    end
    else
    begin
      case (c[3:0])
        4'h0: h = 8'h02;
        4'h1: h = 8'h03;
        4'h2: h = 8'h04;
        4'h4: h = 8'h06;
        4'h5: h = 8'h08;
        4'h7: h = 8'h0c;
        4'h8: h = 8'h10;
        default: h = 8'h00;
      endcase
    end
    return h;
  endfunction : half_ratio

  // Code whose output lands closest to the target; errors are compared
  // cross-multiplied so no divider is needed
  function automatic logic [5:0] pick_code(input ccd_kind_e k, input logic [15:0] khz,
                                           input logic [15:0] tgt, input logic [6:0] ncodes);
    logic [5:0] best;
    logic [31:0] best_err;
    logic [31:0] best_h;
    logic [31:0] h;
    logic [31:0] dbl;
    logic [31:0] prod;
    logic [31:0] err;
    logic found;
    best = 6'h00;
    best_err = 32'h0;
    best_h = 32'h0;
    found = 1'b0;
    dbl = {15'h0, khz, 1'b0};
    for (int i = 0; i < 64; i++)
    begin
      h = {24'h0, half_ratio(k, 6'(i))};
      prod = 32'({16'h0, tgt} * h);
      err = (dbl > prod) ? dbl - prod : prod - dbl;
      if ((7'(i) < ncodes) && (h != 32'h0))
      begin
        if (!found || ((64'(err) * 64'(best_h)) < (64'(best_err) * 64'(h))))
        begin
          best = 6'(i);
          best_err = err;
          best_h = h;
          found = 1'b1;
        end
      end
    end
    return best;
  endfunction : pick_code

endpackage : ccd_pkg

// *** rtl/ccd_half_div.sv ***
/*
  Tick divider with ratios in half steps, so that a ratio of 1.5 is possible.
  Assumes input ticks are single-cycle pulses synchronous to the clock.
*/
`timescale 1ns/1ps
module ccd_half_div #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Tick stream
  input wire logic i_tick,
  input wire logic [W-1:0] i_half,
  output logic o_tick
);

  logic [W:0] acc_r;
  logic [W:0] sum;
  wire logic fire;

  // Each input tick adds two half units; a zero ratio never fires
  assign sum = acc_r + (W+1)'(2);
  assign fire = i_tick && (i_half != '0) && (sum >= {1'b0, i_half});

  // Accumulator keeps the remainder so the average rate is exact
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acc_r <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= fire;
      if (fire)
        acc_r <= sum - {1'b0, i_half};
      else if (i_tick && (i_half != '0))
        acc_r <= sum;
    end
  end

endmodule : ccd_half_div

// *** rtl/ccd_count_div.sv ***
/*
  Integer tick divider with enable: one output tick per i_div input ticks.
  Assumes i_div is at least one; zero is treated as one.
*/
`timescale 1ns/1ps
module ccd_count_div #(
  parameter int W = 18
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_en,
  input wire logic i_tick,
  input wire logic [W-1:0] i_div,
  // Output tick
  output logic o_tick
);

  logic [W-1:0] cnt_r;
  wire logic wrap;

  assign wrap = (cnt_r + W'(1)) >= i_div;

  // Disabled means held at zero, so the first period after enable is full
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end
    else if (!i_en)
    begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= i_tick && wrap;
      if (i_tick)
        cnt_r <= wrap ? '0 : cnt_r + W'(1);
    end
  end

endmodule : ccd_count_div

// *** rtl/ccd_top.sv ***
/*
  Codec auxiliary clock dividers: speaker switching, housekeeping, servo,
  general-purpose output, timeout and debounce clocks, plus master-mode bit
  and frame ticks, with their control registers.
  Assumes every clock here is a tick stream synchronous to I_CLOCK and that the
  system clock rate in kHz is supplied by the clock source logic.
*/
// Functional notes
// - Auto mode picks class D code giving a clock near 768 kHz.
// - Output stage halves the class D clock to about 384 kHz.
// - Auto mode divides system clock to about 256 kHz housekeeping clock.
// - Auto mode divides system clock to about 1.5 MHz servo clock.
// - Class D code: 3 bits, reset 111, read-only, ratios 1 to 16.
// - Housekeeping code: 6 bits, reset 2Fh, read-only, ratio is code plus one.
// - Servo code: 4 bits, reset 1000, automatic, half-step ratios, some reserved.
// - General-purpose output clock from system clock, enable bit 9, reset off.
// - Output clock divider bits 12:10, writable, reset 000, ratios 1 to 16.
// - Output clock reaches pin only when pin selection also chooses it.
// - Timeout clock from 256 kHz clock, runs only while bit 0 set.
// - Timeout divider bits 9:7, reset 000, divides by 256 up to 32768.
// - Debounce clock runs automatically whenever any debouncing is requested.
// - Debounce divider bits 15:13, reset 000, divides by 256 up to 131072.
// - Master mode: bit clock is processing clock over bit clock divider.
// - Master mode: frame clock is bit clock over frame rate divider.
// - System clock keeps running even when serial audio clocks stop.
// - Register reads and writes work with or without system clock.
`timescale 1ns/1ps
module ccd_top #(
  parameter int P_SLOW_BASE_LOG2 = 8
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WRITE,
  input wire logic [15:0] I_REG_WDATA,
  output logic [15:0] O_REG_RDATA,
  // System clock as tick stream and its rate
  input wire logic I_SYSTEM_CLOCK_TICK,
  input wire logic [15:0] I_SYSTEM_CLOCK_KHZ,
  // GPIO side
  input wire logic I_GPIO_SEL_GPCLK,
  input wire logic I_GPIO_DEBOUNCE_REQ,
  input wire logic I_IRQ_DEBOUNCE_REQ,
  // Audio interface
  input wire logic I_MASTER_MODE,
  input wire logic I_PROC_TICK,
  input wire logic [7:0] I_BIT_CLOCK_DIV,
  input wire logic [10:0] I_FRAME_RATE_DIV,
  // Derived clocks
  output logic O_CLASSD_TICK,
  output logic O_SPEAKER_SWITCH,
  output logic O_HOUSEKEEPING_TICK,
  output logic O_SERVO_TICK,
  output logic O_GP_OUTPUT_CLOCK,
  output logic O_TIMEOUT_TICK,
  output logic O_DEBOUNCE_TICK,
  output logic O_BIT_CLOCK_TICK,
  output logic O_FRAME_TICK
);

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [15:0] misc1_r;
  logic [15:0] pwr1_r;
  logic [8:0] clk3_rw_r;
  logic [2:0] spk_code_r;
  logic [5:0] house_code_r;
  logic [3:0] servo_code_r;
  logic [15:0] rate_seen_r;
  logic spk_r;
  logic gp_level_r;
  logic gp_pin_r;

  wire logic hit_clk2;
  wire logic hit_misc1;
  wire logic hit_pwr1;
  wire logic hit_clk3;
  wire logic hit_clk4;
  wire logic [15:0] rd_word;
  wire logic rate_new;
  wire logic [2:0] spk_pick;
  wire logic [5:0] house_pick;
  wire logic [3:0] servo_pick;
  wire logic [2:0] gp_code;
  wire logic [2:0] to_code;
  wire logic [2:0] db_code;
  wire logic gp_en;
  wire logic to_en;
  wire logic db_en;
  wire logic gp_tick;
  wire logic house_tick;
  wire logic [17:0] to_div;
  wire logic [17:0] db_div;
  wire logic [8:0] bit_half;
  wire logic [17:0] frame_div;

  // Address decode, one wire per register
  assign hit_clk2 = (I_REG_ADDR == ccd_pkg::ADDR_CLOCK_CONFIG_TWO);
  assign hit_misc1 = (I_REG_ADDR == ccd_pkg::ADDR_MISC_CONTROL_ONE);
  assign hit_pwr1 = (I_REG_ADDR == ccd_pkg::ADDR_POWER_MANAGEMENT_ONE);
  assign hit_clk3 = (I_REG_ADDR == ccd_pkg::ADDR_CLOCK_CONFIG_THREE);
  assign hit_clk4 = (I_REG_ADDR == ccd_pkg::ADDR_CLOCK_CONFIG_FOUR);

  // Read mux; read-only codes show the live automatic choice
  assign rd_word = hit_clk2 ? 16'(spk_code_r) << ccd_pkg::SPK_DIV_LSB :
                   hit_misc1 ? misc1_r :
                   hit_pwr1 ? pwr1_r :
                   hit_clk3 ? ((16'(clk3_rw_r) << ccd_pkg::CLK3_RW_LSB) |
                               (16'(house_code_r) << ccd_pkg::HOUSE_DIV_LSB)) :
                   hit_clk4 ? 16'(servo_code_r) << ccd_pkg::SERVO_DIV_LSB :
                   16'h0000;

  // Field extraction
  assign gp_en = pwr1_r[ccd_pkg::GP_EN_BIT];
  assign to_en = misc1_r[ccd_pkg::TO_EN_BIT];
  assign gp_code = clk3_rw_r[ccd_pkg::GP_DIV_LSB-ccd_pkg::CLK3_RW_LSB +: 3];
  assign to_code = clk3_rw_r[ccd_pkg::TO_DIV_LSB-ccd_pkg::CLK3_RW_LSB +: 3];
  assign db_code = clk3_rw_r[ccd_pkg::DB_DIV_LSB-ccd_pkg::CLK3_RW_LSB +: 3];

  // ------------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------------
  // Runs on I_CLOCK only, so it never waits on system clock ticks
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      misc1_r <= ccd_pkg::REG_RW_RST;
      pwr1_r <= ccd_pkg::REG_RW_RST;
      clk3_rw_r <= ccd_pkg::CLK3_RW_RST;
      O_REG_RDATA <= 16'h0000;
    end
    else
    begin
      O_REG_RDATA <= rd_word;
      if (I_REG_WRITE && hit_misc1)
        misc1_r <= I_REG_WDATA;
      if (I_REG_WRITE && hit_pwr1)
        pwr1_r <= I_REG_WDATA;
      if (I_REG_WRITE && hit_clk3)
        clk3_rw_r <= I_REG_WDATA[15:ccd_pkg::CLK3_RW_LSB];
    end
  end

  // ------------------------------------------------------------------
  // Automatic divider selection
  // ------------------------------------------------------------------
  // A zero rate means no source is known, so the current codes stay
  assign rate_new = (I_SYSTEM_CLOCK_KHZ != rate_seen_r) && (I_SYSTEM_CLOCK_KHZ != 16'h0000);
  assign spk_pick = 3'(ccd_pkg::pick_code(ccd_pkg::KIND_EIGHT, I_SYSTEM_CLOCK_KHZ,
                       ccd_pkg::TGT_CLASSD_KHZ, ccd_pkg::NCODES_EIGHT));
  assign house_pick = ccd_pkg::pick_code(ccd_pkg::KIND_LINEAR, I_SYSTEM_CLOCK_KHZ,
                       ccd_pkg::TGT_HOUSE_KHZ, ccd_pkg::NCODES_LINEAR);
  assign servo_pick = 4'(ccd_pkg::pick_code(ccd_pkg::KIND_SERVO, I_SYSTEM_CLOCK_KHZ,
                       ccd_pkg::TGT_SERVO_KHZ, ccd_pkg::NCODES_SERVO));

  // Codes ignore register writes and follow only the rate
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      spk_code_r <= ccd_pkg::SPK_DIV_RST;
      house_code_r <= ccd_pkg::HOUSE_DIV_RST;
      servo_code_r <= ccd_pkg::SERVO_DIV_RST;
      rate_seen_r <= 16'h0000;
    end
    else if (rate_new)
    begin
      spk_code_r <= spk_pick;
      house_code_r <= house_pick;
      servo_code_r <= servo_pick;
      rate_seen_r <= I_SYSTEM_CLOCK_KHZ;
    end
  end

  // ------------------------------------------------------------------
  // System clock dividers
  // ------------------------------------------------------------------
  // These keep dividing whenever system ticks arrive (u_gp also needs gp_en), serial clocks or not
  ccd_half_div #(.W(8)) u_classd (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_tick(I_SYSTEM_CLOCK_TICK),
    .i_half(ccd_pkg::half_ratio(ccd_pkg::KIND_EIGHT, {3'h0, spk_code_r})),
    .o_tick(O_CLASSD_TICK)
  );

  ccd_half_div #(.W(8)) u_house (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_tick(I_SYSTEM_CLOCK_TICK),
    .i_half(ccd_pkg::half_ratio(ccd_pkg::KIND_LINEAR, house_code_r)),
    .o_tick(house_tick)
  );

  ccd_half_div #(.W(8)) u_servo (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_tick(I_SYSTEM_CLOCK_TICK),
    .i_half(ccd_pkg::half_ratio(ccd_pkg::KIND_SERVO, {2'h0, servo_code_r})),
    .o_tick(O_SERVO_TICK)
  );

  ccd_half_div #(.W(8)) u_gp (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_tick(I_SYSTEM_CLOCK_TICK && gp_en),
    .i_half(ccd_pkg::half_ratio(ccd_pkg::KIND_EIGHT, {3'h0, gp_code})),
    .o_tick(gp_tick)
  );

  assign O_HOUSEKEEPING_TICK = house_tick;
  assign O_GP_OUTPUT_CLOCK = gp_pin_r;

  // Speaker switching level and gated general-purpose clock
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      spk_r <= 1'b0;
      gp_level_r <= 1'b0;
      gp_pin_r <= 1'b0;
    end
    else
    begin
      if (O_CLASSD_TICK)
        spk_r <= !spk_r;
      if (!gp_en)
        gp_level_r <= 1'b0;
      else if (gp_tick)
        gp_level_r <= !gp_level_r;
      gp_pin_r <= gp_level_r && gp_en && I_GPIO_SEL_GPCLK;
    end
  end

  assign O_SPEAKER_SWITCH = spk_r;

  // ------------------------------------------------------------------
  // Slow clocks from the housekeeping clock
  // ------------------------------------------------------------------
  // Power-of-two ratios; the base exponent is a parameter to shorten runs
  assign to_div = 18'(1) << (P_SLOW_BASE_LOG2 + int'(to_code));
  assign db_div = (db_code == 3'h0) ? 18'(1) << P_SLOW_BASE_LOG2 :
                  18'(1) << (P_SLOW_BASE_LOG2 + ccd_pkg::DB_SKIP_LOG2 + int'(db_code));
  assign db_en = I_GPIO_DEBOUNCE_REQ || I_IRQ_DEBOUNCE_REQ;

  ccd_count_div #(.W(18)) u_timeout (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_en(to_en),
    .i_tick(house_tick),
    .i_div(to_div),
    .o_tick(O_TIMEOUT_TICK)
  );

  ccd_count_div #(.W(18)) u_debounce (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_en(db_en),
    .i_tick(house_tick),
    .i_div(db_div),
    .o_tick(O_DEBOUNCE_TICK)
  );

  // ------------------------------------------------------------------
  // Master-mode serial clocks
  // ------------------------------------------------------------------
  // In slave mode the host owns these clocks and both ticks stay quiet
  assign bit_half = {I_BIT_CLOCK_DIV, 1'b0};
  assign frame_div = {7'h00, I_FRAME_RATE_DIV};

  ccd_half_div #(.W(9)) u_bit (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_tick(I_PROC_TICK && I_MASTER_MODE),
    .i_half(bit_half),
    .o_tick(O_BIT_CLOCK_TICK)
  );

  ccd_count_div #(.W(18)) u_frame (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_en(I_MASTER_MODE),
    .i_tick(O_BIT_CLOCK_TICK),
    .i_div(frame_div),
    .o_tick(O_FRAME_TICK)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence s_pwr_write;
    I_REG_WRITE && hit_pwr1;
  endsequence

  // Read data two cycles after the write shows the written word
  sequence s_pwr_readback;
    O_REG_RDATA == $past(I_REG_WDATA, 2);
  endsequence

  a_speaker_half: assert property (O_CLASSD_TICK |=> (spk_r != $past(spk_r)))
    else $error("speaker level did not flip on class D tick");
  a_classd_pick: assert property (rate_new |=> spk_code_r == $past(spk_pick))
    else $error("class D code not taken from rate");
  a_house_pick: assert property (rate_new |=> house_code_r == $past(house_pick))
    else $error("housekeeping code not taken from rate");
  a_servo_pick: assert property (rate_new |=> servo_code_r == $past(servo_pick))
    else $error("servo code not taken from rate");
  a_codes_readonly: assert property (!rate_new |=> $stable(spk_code_r) && $stable(servo_code_r))
    else $error("read-only code changed without rate change");
  a_gp_gated: assert property (O_GP_OUTPUT_CLOCK |-> $past(gp_en && I_GPIO_SEL_GPCLK))
    else $error("output clock on pin without enable and selection");
  a_timeout_idle: assert property (!to_en |=> !O_TIMEOUT_TICK)
    else $error("timeout tick while disabled");
  a_debounce_auto: assert property (O_DEBOUNCE_TICK |-> $past(db_en))
    else $error("debounce tick without a debounce request");
  a_bit_master: assert property (!I_MASTER_MODE [*2] |-> !O_BIT_CLOCK_TICK)
    else $error("bit clock tick outside master mode");
  a_frame_bit: assert property (O_FRAME_TICK |-> $past(O_BIT_CLOCK_TICK))
    else $error("frame tick not caused by a bit tick");
  a_reg_noclk: assert property (s_pwr_write ##1 hit_pwr1 |=> s_pwr_readback)
    else $error("power register write not read back");

endmodule : ccd_top

// *** tb/ccd_host_clk.sv ***
/*
  Far-side clock source model: system clock and processing clock ticks.
  Assumes the bench holds i_run high for two cycles per wanted tick.
*/
`timescale 1ns/1ps
module ccd_host_clk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_run,
  // Ticks
  output logic o_sys_tick,
  output logic o_proc_tick
);
  // ------------------------------------------------------------------
  // Tick source
  // ------------------------------------------------------------------
  // One source feeds both ticks, so the bit clocks never stop while the
  // system clock keeps running; a stop halts both together
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_sys_tick <= 1'b0;
    else
      // Serial clocks never stop while system ticks run, so no speaker mute
      // or high-pass filter step is ever owed by this host
      o_sys_tick <= i_run & ~o_sys_tick;
  end
  assign o_proc_tick = o_sys_tick;
endmodule : ccd_host_clk

// *** tb/tb_top.sv ***
/*
  Self-checking bench: register access, automatic code choice and tick
  counts of every derived clock.
  Assumes read data shows one cycle after the address is sampled.
*/
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic run = 1'b0;
  logic sys_tick;
  logic proc_tick;
  logic [15:0] khz = 16'h0000;
  logic sel = 1'b0;
  logic gdb = 1'b0;
  logic idb = 1'b0;
  logic master = 1'b0;
  logic [7:0] bdiv = 8'h04;
  logic [10:0] fdiv = 11'h008;
  wire logic [6:0] outs;
  logic spk;
  logic gp;
  logic spk_q = 1'b0;
  logic gp_q = 1'b0;
  int cnt [9];
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  // Slow dividers shortened to /4 so the run stays short
  ccd_top #(.P_SLOW_BASE_LOG2(2)) u_dut (
    .I_CLOCK(clk), .I_RST_N(rst_n),
    .I_REG_ADDR(addr), .I_REG_WRITE(wr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
    .I_SYSTEM_CLOCK_TICK(sys_tick), .I_SYSTEM_CLOCK_KHZ(khz),
    .I_GPIO_SEL_GPCLK(sel), .I_GPIO_DEBOUNCE_REQ(gdb), .I_IRQ_DEBOUNCE_REQ(idb),
    .I_MASTER_MODE(master), .I_PROC_TICK(proc_tick),
    .I_BIT_CLOCK_DIV(bdiv), .I_FRAME_RATE_DIV(fdiv),
    .O_CLASSD_TICK(outs[0]), .O_SPEAKER_SWITCH(spk), .O_HOUSEKEEPING_TICK(outs[1]),
    .O_SERVO_TICK(outs[2]), .O_GP_OUTPUT_CLOCK(gp), .O_TIMEOUT_TICK(outs[3]),
    .O_DEBOUNCE_TICK(outs[4]), .O_BIT_CLOCK_TICK(outs[5]), .O_FRAME_TICK(outs[6])
  );

  ccd_host_clk u_host (
    .i_clk(clk), .i_rst_n(rst_n), .i_run(run),
    .o_sys_tick(sys_tick), .o_proc_tick(proc_tick)
  );

  // ------------------------------------------------------------------
  // Pulse and toggle counting, hang guard
  // ------------------------------------------------------------------
  // Levels are counted by changes, so an output stuck high counts once
  always @(posedge clk)
  begin
    cycles++;
    for (int i = 0; i < 7; i++)
      cnt[i] += int'(outs[i] === 1'b1);
    cnt[7] += int'(spk !== spk_q);
    cnt[8] += int'(gp !== gp_q);
    spk_q = spk;
    gp_q = gp;
    if (cycles == 10000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD reg %h exp %h got %h", a, exp, got);
    end
  endtask : chk_reg

  task automatic chk_cnt(input int i, input int exp);
    samples_checked++;
    if (cnt[i] != exp)
    begin
      fail_count++;
      $display("BAD count %0d exp %0d got %0d", i, exp, cnt[i]);
    end
  endtask : chk_cnt

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk_reg(a, exp, rdata);
  endtask : rd_reg

  // Eight cycles of drain let the last pulses leave the pipeline
  task automatic run_ticks(input int n);
    foreach (cnt[i]) cnt[i] = 0;
    @(posedge clk);
    run <= 1'b1;
    repeat (2 * n) @(posedge clk);
    run <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : run_ticks

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    do_reset();
    rd_reg(8'h08, 16'h01c0);
    rd_reg(8'h1e, 16'h005e);
    rd_reg(8'h38, 16'h0100);
    rd_reg(8'h19, 16'h0000);
    rd_reg(8'h17, 16'h0000);
    wr_reg(8'h08, 16'hffff);
    wr_reg(8'h38, 16'hffff);
    wr_reg(8'h1e, 16'hffff);
    wr_reg(8'h40, 16'hffff);
    rd_reg(8'h08, 16'h01c0);
    rd_reg(8'h38, 16'h0100);
    rd_reg(8'h1e, 16'hffde);
    rd_reg(8'h40, 16'h0000);
    @(posedge clk);
    khz <= 16'h1800;
    rd_reg(8'h08, 16'h0140);
    rd_reg(8'h1e, 16'hffae);
    rd_reg(8'h38, 16'h00a0);
    // A zero rate right after a change must leave the new codes alone
    @(posedge clk);
    khz <= 16'h08ca;
    @(posedge clk);
    khz <= 16'h0000;
    rd_reg(8'h08, 16'h0080);
    rd_reg(8'h1e, 16'hff90);
    rd_reg(8'h38, 16'h0020);
    @(posedge clk);
    khz <= 16'h1800;
    sel <= 1'b1;
    gdb <= 1'b1;
    master <= 1'b1;
    do_reset();
    rd_reg(8'h1e, 16'h002e);
    wr_reg(8'h17, 16'h0001);
    wr_reg(8'h19, 16'h0200);
    wr_reg(8'h1e, 16'h0c80);
    rd_reg(8'h19, 16'h0200);
    run_ticks(768);
    chk_cnt(0, 96);
    chk_cnt(7, 96);
    chk_cnt(1, 32);
    chk_cnt(2, 192);
    chk_cnt(8, 192);
    chk_cnt(3, 4);
    chk_cnt(4, 8);
    chk_cnt(5, 192);
    chk_cnt(6, 24);
    // Gates off, debounce kept alive by the interrupt request alone
    @(posedge clk);
    sel <= 1'b0;
    gdb <= 1'b0;
    idb <= 1'b1;
    master <= 1'b0;
    wr_reg(8'h17, 16'h0000);
    wr_reg(8'h1e, 16'h2c80);
    run_ticks(768);
    chk_cnt(0, 96);
    chk_cnt(8, 0);
    chk_cnt(3, 0);
    chk_cnt(4, 1);
    chk_cnt(5, 0);
    chk_cnt(6, 0);
    summarize();
  end
endmodule : tb_top
